// File: verilog/vbp_option_and_group_select_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "vbp_defs.vh"

// How it works
// - polarity bit selects receive input inversion
// - form bit swaps long and short symbols
// - suspend off: DMA outranks own interrupts
// - suspend on: DMA held while fault flags
// - suspend affects only this block's arbitration
// - loopback feeds tx to rx, pin passive
// - loopback ignores external receive pin
// - group field selects one of nine groups
// - group zero DMA pointers, 1xxx filter quad
// - option_and_group_select register resets to zero
// - slot registers left uninitialised on reset
// - rx address field holds pointer address
// - rx bit 0 selects segment register
// - counter field points to counter or pair
// - counter bit 0 selects register file
// - tx address field holds source pointer
// - tx bit 0 selects segment register
// - counter zero sets pending, clears mask
// - filter bit index equals identifier byte
module vbp_option_and_group_select_regs #(
    parameter NFILT = `VBP_FILTER_REGS
) (
    input  wire       CLK_I,          // core clock
    input  wire       RST_I,          // async reset, high
    input  wire [7:0] ADDR_I,         // register page address
    input  wire [7:0] WDATA_I,        // write data
    input  wire       WR_I,           // write strobe
    input  wire       RD_I,           // read strobe
    output reg  [7:0] RDATA_O,        // read data
    input  wire       BUS_RX_INPUT_I, // external receive pin
    input  wire       CORE_TX_I,      // internal transmit from encoder
    input  wire       TX_PASSIVE_I,   // passive level of transmit pin
    output reg        BUS_TX_OUTPUT_O,// external transmit pin
    output reg        CORE_RX_O,      // normalised receive to decoder
    output reg        NB0_LONG_O,     // norm bit zero uses long symbol
    input  wire       ERR_FLAG_I,     // error status flag
    input  wire       TLA_FLAG_I,     // lost arbitration flag
    input  wire       RX_DMA_REQ_I,   // raw receive DMA request
    input  wire       TX_DMA_REQ_I,   // raw transmit DMA request
    input  wire       RX_TC_ZERO_I,   // rx counter reached zero (pulse)
    input  wire       TX_TC_ZERO_I,   // tx counter reached zero (pulse)
    input  wire       RX_EOB_CLR_I,   // software clears rx pending
    input  wire       TX_EOB_CLR_I,   // software clears tx pending
    input  wire       RX_DMA_EN_SET_I,// software sets rx DMA mask
    input  wire       TX_DMA_EN_SET_I,// software sets tx DMA mask
    output reg        RX_DMA_GNT_O,   // rx DMA request to controller
    output reg        TX_DMA_GNT_O,   // tx DMA request to controller
    output reg        DMA_OVER_IRQ_O, // DMA outranks own interrupts
    output reg        RX_EOB_O,       // rx end-of-block pending
    output reg        TX_EOB_O,       // tx end-of-block pending
    output reg        RX_DMA_EN_O,    // rx DMA mask bit
    output reg        TX_DMA_EN_O,    // tx DMA mask bit
    output reg  [7:0] RX_ADDR_PTR_O,  // rx address pointer register
    output reg  [7:0] RX_CNT_PTR_O,   // rx counter pointer register
    output reg  [7:0] TX_ADDR_PTR_O,  // tx address pointer register
    output reg  [7:0] TX_CNT_PTR_O,   // tx counter pointer register
    input  wire [7:0] FILTER_ID_I,    // identifier byte to look up
    output reg        FILTER_HIT_O    // identifier accepted
);

// ==========================================================
// option register
reg  [7:0] option_and_group_select_q;
wire       pol_sel   = option_and_group_select_q[`VBP_BIT_POL];
wire       loop_en   = option_and_group_select_q[`VBP_BIT_LOOP];
wire       susp_en   = option_and_group_select_q[`VBP_BIT_SUSP];
wire [3:0] group_sel = option_and_group_select_q[`VBP_GRP_MSB:0];
wire       grp_dma   = (group_sel == `VBP_GRP_DMA);
wire       grp_filt  = group_sel[`VBP_GRP_FILT_BIT];
wire       grp_valid = grp_dma | grp_filt;
wire       slot_hit  = ((ADDR_I & 8'hFC) == `VBP_ADDR_SLOT0);

always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
        option_and_group_select_q <= `VBP_OPTION_AND_GROUP_SELECT_RESET;
    end else if (WR_I && ADDR_I == `VBP_ADDR_OPTION_AND_GROUP_SELECT) begin
        option_and_group_select_q <= WDATA_I;
    end
end

// ==========================================================
// stacked registers, no reset
reg [7:0] dma_ptr_q [0:3];
reg [7:0] filt_q    [0:NFILT-1];
wire [4:0] filt_base = {group_sel[2:0], 2'b00};

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_dma
        always @(posedge CLK_I) begin
            if (WR_I && slot_hit && grp_dma && ADDR_I[1:0] == gi) begin
                dma_ptr_q[gi] <= WDATA_I;
            end
        end
    end
    for (gi = 0; gi < NFILT; gi = gi + 1) begin : g_filt
        always @(posedge CLK_I) begin
            if (WR_I && slot_hit && grp_filt && (filt_base + {3'b000, ADDR_I[1:0]}) == gi) begin
                filt_q[gi] <= WDATA_I;
            end
        end
    end
endgenerate

// ==========================================================
// read path
reg [7:0] rd_d;
always @* begin
    rd_d = 8'h00;
    if (ADDR_I == `VBP_ADDR_OPTION_AND_GROUP_SELECT) begin
        rd_d = option_and_group_select_q;
    end else if (slot_hit && grp_dma) begin
        rd_d = dma_ptr_q[ADDR_I[1:0]];
    end else if (slot_hit && grp_filt) begin
        rd_d = filt_q[filt_base + {3'b000, ADDR_I[1:0]}];
    end else if (slot_hit && !grp_valid) begin
        rd_d = 8'h00;
    end
end

always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
        RDATA_O <= 8'h00;
    end else if (RD_I) begin
        RDATA_O <= rd_d;
    end
end

// ==========================================================
// line path, symbol form, filter lookup
wire [7:0] filt_byte = filt_q[FILTER_ID_I[7:3]];
always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
        BUS_TX_OUTPUT_O <= 1'b0;
        CORE_RX_O       <= 1'b0;
        NB0_LONG_O      <= 1'b1;
        FILTER_HIT_O    <= 1'b0;
    end else begin
        BUS_TX_OUTPUT_O <= loop_en ? TX_PASSIVE_I : CORE_TX_I;
        CORE_RX_O       <= loop_en ? CORE_TX_I
                         : (pol_sel ? BUS_RX_INPUT_I : ~BUS_RX_INPUT_I);
        NB0_LONG_O      <= ~option_and_group_select_q[`VBP_BIT_NBF];
        FILTER_HIT_O    <= filt_byte[FILTER_ID_I[2:0]];
    end
end

// ==========================================================
// DMA gating and end of block
wire fault     = ERR_FLAG_I | TLA_FLAG_I;
wire dma_allow = ~(susp_en & fault);
always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
        RX_DMA_GNT_O   <= 1'b0;
        TX_DMA_GNT_O   <= 1'b0;
        DMA_OVER_IRQ_O <= 1'b1;
        RX_EOB_O       <= 1'b0;
        TX_EOB_O       <= 1'b0;
        RX_DMA_EN_O    <= 1'b0;
        TX_DMA_EN_O    <= 1'b0;
        RX_ADDR_PTR_O  <= 8'h00;
        RX_CNT_PTR_O   <= 8'h00;
        TX_ADDR_PTR_O  <= 8'h00;
        TX_CNT_PTR_O   <= 8'h00;
    end else begin
        DMA_OVER_IRQ_O <= ~susp_en;
        RX_DMA_GNT_O   <= RX_DMA_REQ_I & RX_DMA_EN_O & ~RX_TC_ZERO_I & dma_allow;
        TX_DMA_GNT_O   <= TX_DMA_REQ_I & TX_DMA_EN_O & ~TX_TC_ZERO_I & dma_allow;
        RX_EOB_O       <= RX_TC_ZERO_I | (RX_EOB_O & ~RX_EOB_CLR_I);
        TX_EOB_O       <= TX_TC_ZERO_I | (TX_EOB_O & ~TX_EOB_CLR_I);
        RX_DMA_EN_O    <= ~RX_TC_ZERO_I & (RX_DMA_EN_O | RX_DMA_EN_SET_I);
        TX_DMA_EN_O    <= ~TX_TC_ZERO_I & (TX_DMA_EN_O | TX_DMA_EN_SET_I);
        RX_ADDR_PTR_O  <= dma_ptr_q[0];
        RX_CNT_PTR_O   <= dma_ptr_q[1];
        TX_ADDR_PTR_O  <= dma_ptr_q[2];
        TX_CNT_PTR_O   <= dma_ptr_q[3];
    end
end

endmodule
`default_nettype wire

// File: verilog/vbp_defs.vh
`ifndef VBP_DEFS_VH
`define VBP_DEFS_VH
`define VBP_ADDR_OPTION_AND_GROUP_SELECT   8'hFB
`define VBP_ADDR_SLOT0     8'hFC
`define VBP_ADDR_SLOT1     8'hFD
`define VBP_ADDR_SLOT2     8'hFE
`define VBP_ADDR_SLOT3     8'hFF
`define VBP_OPTION_AND_GROUP_SELECT_RESET  8'h00
`define VBP_BIT_POL        7
`define VBP_BIT_NBF        6
`define VBP_BIT_SUSP       5
`define VBP_BIT_LOOP       4
`define VBP_GRP_MSB        3
`define VBP_GRP_DMA        4'h0
`define VBP_GRP_FILT_BIT   3
`define VBP_FILTER_REGS    32
`endif

// File: tb/vbp_dma_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// dma controller: every grant moves one unit, the last one of a block pulses counter zero
module vbp_dma_model #(parameter int N = 3) (
    input  wire logic CLK_I,     // core clock
    input  wire logic RST_I,     // async reset, high
    input  wire logic gnt_i,     // request from the block
    output var  logic tc_zero_o  // transaction counter hit zero
);
    int cnt_q;
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_q <= N;
            tc_zero_o <= 1'b0;
        end else begin
            tc_zero_o <= gnt_i && cnt_q == 1;
            if (gnt_i)
                cnt_q <= (cnt_q == 1) ? N : cnt_q - 1;
        end
    end
endmodule
`default_nettype wire

// File: tb/vbp_option_and_group_select_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module vbp_option_and_group_select_regs_assertions (
    input wire logic       CLK_I, RST_I, WR_I, RD_I, CORE_TX_I, TX_PASSIVE_I, ERR_FLAG_I, TLA_FLAG_I,
    input wire logic       RX_DMA_REQ_I, RX_TC_ZERO_I, TX_TC_ZERO_I, BUS_TX_OUTPUT_O, CORE_RX_O, NB0_LONG_O,
    input wire logic       RX_DMA_GNT_O, TX_DMA_GNT_O, DMA_OVER_IRQ_O, RX_EOB_O, TX_EOB_O, RX_DMA_EN_O, TX_DMA_EN_O,
    input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_form; WR_I && ADDR_I == 8'hFB |-> ##2 NB0_LONG_O == !$past(WDATA_I[6], 2); endproperty
    a_form: assert property (p_form) else $error("form select not followed");
    property p_susp; WR_I && ADDR_I == 8'hFB |-> ##2 DMA_OVER_IRQ_O == !$past(WDATA_I[5], 2); endproperty
    a_susp: assert property (p_susp) else $error("suspend select not followed");
    property p_hold; !DMA_OVER_IRQ_O && $past(!DMA_OVER_IRQ_O) && (ERR_FLAG_I || TLA_FLAG_I)
        |=> !RX_DMA_GNT_O && !TX_DMA_GNT_O; endproperty
    a_hold: assert property (p_hold) else $error("dma granted during fault");
    property p_pass; DMA_OVER_IRQ_O && $past(DMA_OVER_IRQ_O) && RX_DMA_REQ_I && RX_DMA_EN_O && !RX_TC_ZERO_I
        |=> RX_DMA_GNT_O; endproperty
    a_pass: assert property (p_pass) else $error("dma withheld without suspend");
    property p_loop; !$past(RST_I) && $past(CORE_TX_I) != $past(TX_PASSIVE_I)
        && BUS_TX_OUTPUT_O == $past(TX_PASSIVE_I) |-> CORE_RX_O == $past(CORE_TX_I); endproperty
    a_loop: assert property (p_loop) else $error("loopback path wrong");
    property p_nolp; !$past(RST_I) && BUS_TX_OUTPUT_O != $past(TX_PASSIVE_I)
        |-> BUS_TX_OUTPUT_O == $past(CORE_TX_I); endproperty
    a_nolp: assert property (p_nolp) else $error("tx pin not from core");
    property p_rxeob; RX_TC_ZERO_I |=> RX_EOB_O && !RX_DMA_EN_O && !RX_DMA_GNT_O; endproperty
    a_rxeob: assert property (p_rxeob) else $error("rx end of block wrong");
    property p_txeob; TX_TC_ZERO_I |=> TX_EOB_O && !TX_DMA_EN_O && !TX_DMA_GNT_O; endproperty
    a_txeob: assert property (p_txeob) else $error("tx end of block wrong");
    property p_unmap; RD_I && ADDR_I < 8'hFB |=> RDATA_O == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind vbp_option_and_group_select_regs vbp_option_and_group_select_regs_assertions i_chk (.*);
`default_nettype wire

// File: tb/vbp_option_and_group_select_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module vbp_option_and_group_select_regs_bench;
    logic CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, BUS_RX_INPUT_I = 0, CORE_TX_I = 0, TX_PASSIVE_I = 0;
    logic ERR_FLAG_I = 0, TLA_FLAG_I = 0, RX_DMA_REQ_I = 0, TX_DMA_REQ_I = 0, RX_EOB_CLR_I = 0, TX_EOB_CLR_I = 0;
    logic RX_DMA_EN_SET_I = 0, TX_DMA_EN_SET_I = 0, RX_TC_ZERO_I, TX_TC_ZERO_I, BUS_TX_OUTPUT_O, CORE_RX_O;
    logic NB0_LONG_O, RX_DMA_GNT_O, TX_DMA_GNT_O, DMA_OVER_IRQ_O, RX_EOB_O, TX_EOB_O, RX_DMA_EN_O, TX_DMA_EN_O;
    logic FILTER_HIT_O;
    logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, FILTER_ID_I = 8'h00, RDATA_O;
    logic [7:0] RX_ADDR_PTR_O, RX_CNT_PTR_O, TX_ADDR_PTR_O, TX_CNT_PTR_O;
    int   n_errors = 0, compares = 0, cyc = 0;
    vbp_option_and_group_select_regs i_vbp_option_and_group_select_regs (.*);
    vbp_dma_model i_rx_dma (.CLK_I(CLK_I), .RST_I(RST_I), .gnt_i(RX_DMA_GNT_O), .tc_zero_o(RX_TC_ZERO_I));
    vbp_dma_model i_tx_dma (.CLK_I(CLK_I), .RST_I(RST_I), .gnt_i(TX_DMA_GNT_O), .tc_zero_o(TX_TC_ZERO_I));
    always #25 CLK_I = ~CLK_I;
    always @(posedge CLK_I) if (++cyc == 4000) begin n_errors++; tally_and_finish(); end
    // ==========
    // access tasks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin n_errors++; $display("MISMATCH %s expected %h seen %h", nm, exp, seen); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK_I); ADDR_I <= a; WDATA_I <= d; WR_I <= 1;
        @(posedge CLK_I); WR_I <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK_I); ADDR_I <= a; RD_I <= 1;
        @(posedge CLK_I); RD_I <= 0;
        @(posedge CLK_I); #1 chk("rdata", RDATA_O, exp);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK_I);
        RST_I <= 0;
        rd(8'hFB, 8'h00);
        rd(8'hF0, 8'h00);
        chk("nb0", NB0_LONG_O, 8'h01);
        for (int g = 0; g < 16; g++) for (int a = 0; a < 4; a++) begin
            wr(8'hFB, 8'(g)); wr(8'(252 + a), 8'(g * 16 + a + 1));
        end
        for (int g = 0; g < 16; g++) for (int a = 0; a < 4; a++) begin
            wr(8'hFB, 8'(g)); rd(8'(252 + a), (g > 0 && g < 8) ? 8'h00 : 8'(g * 16 + a + 1));
        end
        wr(8'hFB, 8'h00);
        rd(8'hFC, 8'h01);
        $display("stacked groups done");
        chk("rxa", RX_ADDR_PTR_O, 8'h01);
        chk("rxc", RX_CNT_PTR_O, 8'h02);
        chk("txa", TX_ADDR_PTR_O, 8'h03);
        chk("txc", TX_CNT_PTR_O, 8'h04);
        for (int id = 0; id < 256; id++) begin
            @(posedge CLK_I); FILTER_ID_I <= 8'(id);
            @(posedge CLK_I); #1 chk("hit", FILTER_HIT_O, 8'((((8 + id / 32) * 16 + (id / 8) % 4 + 1) >> (id % 8)) & 1));
        end
        $display("filter lookup done");
        wr(8'hFB, 8'h00); BUS_RX_INPUT_I <= 1; CORE_TX_I <= 1;
        repeat (2) @(posedge CLK_I); #1 chk("rx", CORE_RX_O, 8'h00);
        chk("txpin", BUS_TX_OUTPUT_O, 8'h01);
        wr(8'hFB, 8'h80); repeat (2) @(posedge CLK_I); #1 chk("rx", CORE_RX_O, 8'h01);
        wr(8'hFB, 8'hD0); BUS_RX_INPUT_I <= 0;
        repeat (2) @(posedge CLK_I); #1 chk("rx", CORE_RX_O, 8'h01);
        chk("txpin", BUS_TX_OUTPUT_O, 8'h00);
        chk("nb0", NB0_LONG_O, 8'h00);
        $display("line option_and_group_select done");
        wr(8'hFB, 8'h00); ERR_FLAG_I <= 1; RX_DMA_REQ_I <= 1; TX_DMA_REQ_I <= 1;
        RX_DMA_EN_SET_I <= 1; TX_DMA_EN_SET_I <= 1;
        @(posedge CLK_I); RX_DMA_EN_SET_I <= 0; TX_DMA_EN_SET_I <= 0;
        #1 for (int i = 0; i < 20 && (RX_EOB_O !== 1'b1 || TX_EOB_O !== 1'b1); i++) #50;
        chk("eob", {RX_EOB_O, TX_EOB_O, RX_DMA_EN_O, TX_DMA_EN_O}, 8'h0C);
        wr(8'hFB, 8'h20); RX_EOB_CLR_I <= 1; TX_EOB_CLR_I <= 1; RX_DMA_EN_SET_I <= 1; TX_DMA_EN_SET_I <= 1;
        @(posedge CLK_I); RX_EOB_CLR_I <= 0; TX_EOB_CLR_I <= 0; RX_DMA_EN_SET_I <= 0; TX_DMA_EN_SET_I <= 0;
        @(posedge CLK_I); ERR_FLAG_I <= 0; TLA_FLAG_I <= 1;
        repeat (2) @(posedge CLK_I); #1 chk("gnt", {RX_DMA_GNT_O, TX_DMA_GNT_O, RX_EOB_O}, 8'h00);
        @(posedge CLK_I); TLA_FLAG_I <= 0;
        repeat (2) @(posedge CLK_I); #1 chk("gnt", {RX_DMA_GNT_O, TX_DMA_GNT_O, DMA_OVER_IRQ_O}, 8'h06);
        $display("dma option_and_group_select done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
